/* File: rtl/mtsp_tx_path.sv */
/*
  Transmit symbol path: async-to-sync rate converter, scrambler,
  differential quadrant encoder, band routing and FSK tone source.
  Assumes txd_i is an asynchronous pin and the register master
  is on mclk_i; the analog filters take the route outputs.
*/
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module mtsp_tx_path
  import mtsp_pkg::*;
#(
  parameter int unsigned BIT_CYC_HI_P = BIT_CYC_HI, // clocks per bit, 2400
  parameter int unsigned BIT_CYC_LO_P = BIT_CYC_LO  // clocks per bit, 1200
) (
  input  wire logic       mclk_i,      // master clock
  input  wire logic       sys_rst_i,   // async reset, high
  input  wire logic [3:0] addr_i,      // register address
  input  wire logic [7:0] wdata_i,     // write data
  input  wire logic       wr_i,        // write strobe
  input  wire logic       rd_i,        // read strobe
  output logic [7:0]      rdata_o,     // read data, next cycle
  input  wire logic       txd_i,       // async serial data
  output logic            sync_bit_o,  // converter output bit
  output mtsp_sym_s       sym_o,       // symbol to modulator
  output logic            sym_stb_o,   // new symbol pulse
  output mtsp_route_s     route_o,     // filter and level setup
  output logic [7:0]      fsk_phase_o, // tone phase
  output logic            fsk_tone_o   // square tone
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mtsp_rx_e;
  typedef enum logic [1:0] {TX_STOP, TX_START, TX_DATA} mtsp_tx_e;

  typedef struct packed {
    logic [1:0]  sync;
    mtsp_ctrl_s  ctrl;
    logic [3:0]  atten;
    logic        ovr;
    logic [7:0]  rdata;
    mtsp_rx_e    rx_st;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_n;
    logic [7:0]  rx_sh;
    logic [7:0]  hold;
    logic        hold_vld;
    logic [15:0] tick_cnt;
    mtsp_tx_e    tx_st;
    logic [3:0]  tx_n;
    logic [7:0]  tx_sh;
    logic        tx_bit;
    logic [16:0] scr;
    logic [1:0]  grp;
    mtsp_sym_s   sym;
    logic        stb;
    logic [7:0]  ins_cnt;
    logic [7:0]  del_cnt;
  } mtsp_st_s;

  mtsp_st_s q, d;

  ////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic is_psk(input mtsp_spd_e s);
    return (s == SPD_1200) || (s == SPD_2400);
  endfunction

  // Quarter turns for a dibit, first bit in time on the left
  function automatic logic [1:0] dq_f(input logic [1:0] dib);
    unique case (dib)
      2'b00:   return 2'h1;
      2'b01:   return 2'h0;
      2'b11:   return 2'h3;
      default: return 2'h2;
    endcase
  endfunction

  logic        line;
  logic        psk;
  logic        hi;
  logic [15:0] per_m1;
  logic [15:0] half;
  logic        tick;
  logic        obit;
  logic        sbit;
  logic [16:0] scr_n;
  logic [1:0]  need;
  logic [1:0]  dib;
  logic        emit;
  logic        last;
  mtsp_ctrl_s  wctrl;
  mtsp_stat_s  wstat;

  assign line   = q.sync[1];
  assign psk    = is_psk(q.ctrl.spd);
  assign hi     = (q.ctrl.spd == SPD_2400);
  assign per_m1 = hi ? 16'(BIT_CYC_HI_P - 1) : 16'(BIT_CYC_LO_P - 1);
  assign half   = hi ? 16'(BIT_CYC_HI_P / 2) : 16'(BIT_CYC_LO_P / 2);
  // Fixed output rate from the master clock alone
  assign tick   = (q.tick_cnt >= per_m1);

  assign obit = (q.tx_st == TX_STOP)  ? 1'b1 :
                (q.tx_st == TX_START) ? 1'b0 : q.tx_sh[0];
  assign sbit  = obit ^ q.scr[13] ^ q.scr[16];
  assign scr_n = {q.scr[15:0], sbit};

  // Newest bit sits in stage one, so the older stage comes first
  assign need = hi ? 2'h3 : 2'h1;
  assign dib  = hi ? scr_n[3:2] : scr_n[1:0];
  assign emit = tick && psk && (q.grp == need);
  assign last = (q.tx_n == 4'(CHAR_BITS - 1));
  assign wctrl = mtsp_ctrl_s'(wdata_i);
  assign wstat = mtsp_stat_s'(wdata_i);

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic take;
    logic rx_done;
    logic [7:0] rd_v;
    take    = 1'b0;
    rx_done = 1'b0;
    rd_v    = 8'h00;
    d       = q;
    d.sync  = {q.sync[0], txd_i};
    d.stb   = 1'b0;
    d.rdata = 8'h00;

    if (wr_i) begin
      case (addr_i)
        ADDR_CTRL:  d.ctrl = mtsp_ctrl_s'({2'h0, wdata_i[5:0]});
        ADDR_LEVEL: d.atten = wdata_i[3:0];
        ADDR_STAT:  if (wstat.ovr) d.ovr = 1'b0;
        default:    ;
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        ADDR_CTRL:  rd_v = q.ctrl;
        ADDR_LEVEL: rd_v = {4'h0, q.atten};
        ADDR_STAT:  rd_v = {2'h0, q.ovr, q.hold_vld, q.sym.point, q.sym.quad};
        ADDR_INS:   rd_v = q.ins_cnt;
        ADDR_DEL:   rd_v = q.del_cnt;
        default:    rd_v = 8'h00;
      endcase
      d.rdata = rd_v;
    end

    // Async receiver: each start edge re-times, which absorbs the
    // input rate error over one character
    if (q.rx_cnt != 16'h0) begin
      d.rx_cnt = 16'(q.rx_cnt - 16'h1);
    end
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!line) begin
          d.rx_st  = RX_START;
          d.rx_cnt = half;
        end
      end
      RX_START: begin
        if (q.rx_cnt == 16'h0) begin
          if (line) begin
            d.rx_st = RX_IDLE;
          end else begin
            d.rx_st  = RX_DATA;
            d.rx_cnt = per_m1;
            d.rx_n   = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (q.rx_cnt == 16'h0) begin
          d.rx_sh  = {line, q.rx_sh[7:1]};
          d.rx_cnt = per_m1;
          if (q.rx_n == 4'(CHAR_BITS - 1)) begin
            d.rx_st = RX_STOP;
          end else begin
            d.rx_n = 4'(q.rx_n + 4'h1);
          end
        end
      end
      RX_STOP: begin
        if (q.rx_cnt == 16'h0) begin
          d.rx_st = RX_IDLE;
          rx_done = line;
        end
      end
    endcase

    // Fixed-rate side
    d.tick_cnt = tick ? 16'h0 : 16'(q.tick_cnt + 16'h1);
    if (tick && psk) begin
      d.tx_bit = obit;
      unique case (q.tx_st)
        TX_STOP: begin
          if (q.hold_vld) begin
            take = 1'b1;
          end else begin
            d.ins_cnt = 8'(q.ins_cnt + 8'h1);
          end
        end
        TX_START: begin
          d.tx_st = TX_DATA;
          d.tx_n  = 4'h0;
        end
        TX_DATA: begin
          d.tx_sh = {1'b0, q.tx_sh[7:1]};
          if (!last) begin
            d.tx_n = 4'(q.tx_n + 4'h1);
          end else if (q.hold_vld && (q.rx_st != RX_IDLE)) begin
            // Next character waiting and another one already
            // arriving: skip this stop bit to catch up
            take      = 1'b1;
            d.del_cnt = 8'(q.del_cnt + 8'h1);
          end else begin
            d.tx_st = TX_STOP;
          end
        end
      endcase
      if (take) begin
        d.tx_st    = TX_START;
        d.tx_sh    = q.hold;
        d.hold_vld = 1'b0;
      end

      d.scr = scr_n;
      if (emit) begin
        d.grp      = 2'h0;
        d.stb      = 1'b1;
        d.sym.quad = 2'(q.sym.quad + dq_f(dib));
        d.sym.point = hi ? scr_n[1:0] : PT_1200;
      end else begin
        d.grp = 2'(q.grp + 2'h1);
      end
    end

    // A new character wins over the slot just freed
    if (rx_done) begin
      if (d.hold_vld) begin
        d.ovr = 1'b1;
      end else begin
        d.hold     = q.rx_sh;
        d.hold_vld = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q       <= '0;
      q.sync  <= LINE_IDLE;
      q.ctrl  <= mtsp_ctrl_s'(CTRL_RST);
      q.atten <= ATTEN_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign rdata_o    = q.rdata;
  assign sync_bit_o = q.tx_bit;
  assign sym_o      = q.sym;
  assign sym_stb_o  = q.stb;

  always_comb begin
    route_o.tx_hi      = q.ctrl.answer;
    route_o.rx_hi      = !q.ctrl.answer;
    route_o.notch_1800 = q.ctrl.notch;
    route_o.fsk_en     = !psk;
    route_o.atten      = q.atten;
  end

  mtsp_fsk_gen u_fsk (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .en_i      (!psk),
    .std_i     (q.ctrl.std),
    .answer_i  (q.ctrl.answer),
    .mark_i    (line),
    .phase_o   (fsk_phase_o),
    .tone_o    (fsk_tone_o)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_scr;
    tick && psk |=> q.scr[16:1] == $past(q.scr[15:0]) &&
      q.scr[0] == ($past(obit) ^ $past(q.scr[13]) ^ $past(q.scr[16]));
  endproperty
  a_scr: assert property (p_scr) else $error("scrambler step wrong");

  property p_ins;
    tick && psk && q.tx_st == TX_STOP && !q.hold_vld |=>
      q.tx_st == TX_STOP && sync_bit_o &&
      q.ins_cnt == 8'($past(q.ins_cnt) + 8'h1);
  endproperty
  a_ins: assert property (p_ins) else $error("stop bit not inserted");

  sequence s_del_cond;
    tick && psk && q.tx_st == TX_DATA && last && q.hold_vld && q.rx_st != RX_IDLE;
  endsequence
  sequence s_del_done;
    q.tx_st == TX_START && q.del_cnt == 8'($past(q.del_cnt) + 8'h1) ##1 (obit == 1'b0)[*1];
  endsequence
  property p_del;
    s_del_cond |=> s_del_done;
  endproperty
  a_del: assert property (p_del) else $error("stop bit not deleted");

  property p_rate;
    tick && psk && hi && q.grp == 2'h3 |=> sym_stb_o && q.grp == 2'h0;
  endproperty
  a_rate: assert property (p_rate) else $error("quadbit symbol missed");

  property p_quad_hi;
    sym_stb_o && $past(hi) |->
      sym_o.quad == 2'($past(sym_o.quad) + dq_f(q.scr[3:2]));
  endproperty
  a_quad_hi: assert property (p_quad_hi) else $error("quadbit quadrant wrong");

  property p_point;
    sym_stb_o && $past(hi) |-> sym_o.point == q.scr[1:0];
  endproperty
  a_point: assert property (p_point) else $error("quadbit point wrong");

  property p_quad_lo;
    sym_stb_o && !$past(hi) |-> sym_o.point == PT_1200 &&
      sym_o.quad == 2'($past(sym_o.quad) + dq_f(q.scr[1:0]));
  endproperty
  a_quad_lo: assert property (p_quad_lo) else $error("dibit quadrant wrong");

  property p_band;
    wr_i && addr_i == ADDR_CTRL |=> route_o.rx_hi != route_o.tx_hi &&
      route_o.tx_hi == $past(wctrl.answer);
  endproperty
  a_band: assert property (p_band) else $error("band routing wrong");

  property p_notch;
    wr_i && addr_i == ADDR_CTRL |=>
      route_o.notch_1800 == $past(wctrl.notch);
  endproperty
  a_notch: assert property (p_notch) else $error("notch select wrong");

  property p_atten;
    wr_i && addr_i == ADDR_LEVEL |=> route_o.atten == $past(wdata_i[3:0]);
  endproperty
  a_atten: assert property (p_atten) else $error("level step wrong");

endmodule

/* File: rtl/mtsp_pkg.sv */
/*
  Shared constants and types of the modem transmit symbol path.
  Assumes a 50 MHz master clock and an 8-bit register port.
*/
package mtsp_pkg;

  // Timing
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned RATE_HI_HZ = 2400;
  localparam int unsigned RATE_LO_HZ = 1200;
  localparam int unsigned BIT_CYC_HI = CLK_HZ / RATE_HI_HZ;
  localparam int unsigned BIT_CYC_LO = CLK_HZ / RATE_LO_HZ;
  localparam int unsigned CHAR_BITS  = 8;

  // Register offsets
  localparam logic [3:0] ADDR_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_LEVEL = 4'h1;
  localparam logic [3:0] ADDR_STAT  = 4'h2;
  localparam logic [3:0] ADDR_INS   = 4'h3;
  localparam logic [3:0] ADDR_DEL   = 4'h4;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [3:0] ATTEN_RST = 4'h0;
  localparam logic [1:0] LINE_IDLE = 2'h3;

  // Point used for every 1200 bps symbol
  localparam logic [1:0] PT_1200 = 2'h1;

  // Tone synthesiser
  localparam int unsigned ACC_W = 24;
  localparam int unsigned BELL_OM = 1270, BELL_OS = 1070;
  localparam int unsigned BELL_AM = 2225, BELL_AS = 2025;
  localparam int unsigned V21_OM  = 980,  V21_OS  = 1180;
  localparam int unsigned V21_AM  = 1650, V21_AS  = 1850;
  localparam int unsigned V23_OM  = 390,  V23_OS  = 450;
  localparam int unsigned V23_AM  = 1300, V23_AS  = 2100;

  typedef enum logic [1:0] {SPD_FSK, SPD_1200, SPD_2400} mtsp_spd_e;
  typedef enum logic [1:0] {STD_BELL, STD_V21, STD_V23} mtsp_std_e;

  typedef struct packed {
    logic [1:0] rsvd;
    mtsp_std_e  std;
    logic       notch;
    logic       answer;
    mtsp_spd_e  spd;
  } mtsp_ctrl_s;

  typedef struct packed {
    logic [1:0] rsvd;
    logic       ovr;
    logic       hold;
    logic [1:0] point;
    logic [1:0] quad;
  } mtsp_stat_s;

  typedef struct packed {
    logic [1:0] quad;
    logic [1:0] point;
  } mtsp_sym_s;

  typedef struct packed {
    logic       tx_hi;
    logic       rx_hi;
    logic       notch_1800;
    logic       fsk_en;
    logic [3:0] atten;
  } mtsp_route_s;

  // Rounded phase step for a tone at the master clock rate
  function automatic logic [ACC_W-1:0] fsk_inc(input int unsigned hz);
    longint unsigned v;
    v = (longint'(hz) * (64'd1 << ACC_W) + longint'(CLK_HZ / 2)) / longint'(CLK_HZ);
    return v[ACC_W-1:0];
  endfunction

endpackage

/* File: rtl/mtsp_fsk_gen.sv */
/*
  Phase-continuous tone synthesiser for the low-speed modes.
  Assumes mark_i is already synchronous to mclk_i.
*/
`timescale 1ns/1ps
module mtsp_fsk_gen
  import mtsp_pkg::*;
(
  input  wire logic       mclk_i,    // master clock
  input  wire logic       sys_rst_i, // async reset, high
  input  wire logic       en_i,      // low-speed mode active
  input  mtsp_std_e       std_i,     // tone set
  input  wire logic       answer_i,  // answer side tones
  input  wire logic       mark_i,    // data level
  output logic [7:0]      phase_o,   // phase, top bits
  output logic            tone_o     // square tone
);

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } mtsp_fsk_st_s;

  mtsp_fsk_st_s q, d;
  logic [ACC_W-1:0] inc;

  always_comb begin
    unique case ({answer_i, mark_i})
      2'b00:   inc = (std_i == STD_V21) ? fsk_inc(V21_OS) :
                     (std_i == STD_V23) ? fsk_inc(V23_OS) : fsk_inc(BELL_OS);
      2'b01:   inc = (std_i == STD_V21) ? fsk_inc(V21_OM) :
                     (std_i == STD_V23) ? fsk_inc(V23_OM) : fsk_inc(BELL_OM);
      2'b10:   inc = (std_i == STD_V21) ? fsk_inc(V21_AS) :
                     (std_i == STD_V23) ? fsk_inc(V23_AS) : fsk_inc(BELL_AS);
      default: inc = (std_i == STD_V21) ? fsk_inc(V21_AM) :
                     (std_i == STD_V23) ? fsk_inc(V23_AM) : fsk_inc(BELL_AM);
    endcase
  end

  // Only the step changes on a data edge, so the phase never jumps while en_i is high
  always_comb begin
    d = q;
    if (en_i) begin
      d.acc = q.acc + inc;
    end else begin
      d.acc = '0;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase_o = q.acc[ACC_W-1 -: 8];
  assign tone_o  = q.acc[ACC_W-1];

endmodule

/* File: tb/mtsp_serial_src.sv */
/*
  Serial character source standing in for the terminal on txd_i.
  Assumes the caller picks a bit time within the tolerated rate error.
*/
`timescale 1ns/1ps
module mtsp_serial_src (
  output logic txd_o // serial line, mark when idle
);
  initial txd_o = 1'b1;

  task automatic level(input logic v);
    txd_o <= v;
  endtask

  // Start, eight data bits LSB first, one stop; line is never left undriven
  task automatic send_char(input logic [7:0] c, input real bit_ns);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd_o = fr[i];
      #(bit_ns);
    end
  endtask
endmodule

/* File: tb/tb_modem_transmit_symbol_path.sv */
/*
  Self-checking bench of the transmit symbol path: registers, routing,
  tones, rate converter, scrambler and quadrant encoder.
  Assumes shortened bit periods and the serial source model on txd_i.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_modem_transmit_symbol_path import mtsp_pkg::*;;
  localparam int PH = 40;
  localparam int PL = 80;
  localparam logic [1:0] DIB [4] = '{2'h1, 2'h0, 2'h2, 2'h3};
  localparam int unsigned HZ [12] = '{BELL_OS, BELL_OM, BELL_AS, BELL_AM, V21_OS, V21_OM,
                                      V21_AS, V21_AM, V23_OS, V23_OM, V23_AS, V23_AM};
  logic        mclk_i    = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic [3:0]  addr_i    = 4'h0;
  logic [7:0]  wdata_i   = 8'h00;
  logic [7:0]  rdata_o;
  logic [7:0]  fsk_phase_o;
  wire         txd_i;
  logic        sync_bit_o;
  logic        sym_stb_o;
  logic        fsk_tone_o;
  mtsp_sym_s   sym_o;
  mtsp_route_s route_o;
  int          fails     = 0;
  int          n_tests   = 0;
  int          cyc       = 0;
  int          adv, per, nb, ph, t_stb, warm, st, ins, dels, got;
  bit          mon       = 1'b0;
  bit          psk_on    = 1'b0;
  bit          synced;
  logic        bad;
  logic [7:0]  prev, dph, ch;
  logic [1:0]  q_prev;
  logic [16:0] h;
  logic [3:0]  db;
  logic [7:0]  expq [$];
  logic [31:0] seed      = 32'h0000_0038;

  always #10 mclk_i = ~mclk_i;

  mtsp_tx_path #(.BIT_CYC_HI_P(PH), .BIT_CYC_LO_P(PL)) dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txd_i(txd_i),
    .sync_bit_o(sync_bit_o), .sym_o(sym_o), .sym_stb_o(sym_stb_o),
    .route_o(route_o), .fsk_phase_o(fsk_phase_o), .fsk_tone_o(fsk_tone_o)
  );
  mtsp_serial_src src (.txd_o(txd_i));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
    @(negedge mclk_i);
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Rebuild the serial characters from the converter output
  task automatic parse(input logic b);
    logic [7:0] e;
    if (st == 0) begin
      if (b == 1'b0) st = 1;
      else if (got > 0 && expq.size() != 0) ins++;
    end else if (st < 9) begin
      ch[st-1] = b;
      st++;
    end else begin
      e = (expq.size() != 0) ? expq.pop_front() : ~ch;
      `CHK(ch, e)
      got++;
      if (b == 1'b0) begin
        dels++;
        st = 1;
      end else st = 0;
    end
  endtask

  // Recover scrambled bits from the symbols, then undo the scrambler
  task automatic sym_chk();
    logic [3:0] s;
    logic [1:0] c;
    c = sym_o.quad - q_prev;
    s = (nb == 4) ? {DIB[c], sym_o.point} : {2'b00, DIB[c]};
    if (nb == 2) `CHK(sym_o.point, PT_1200)
    for (int k = nb - 1; k >= 0; k--) begin
      if (warm * nb >= 20) `CHK(s[k] ^ h[13] ^ h[16], db[k])
      h = {h[15:0], s[k]};
    end
    q_prev = sym_o.quad;
    warm++;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge mclk_i) begin
    if (mon) begin
      dph = fsk_phase_o - prev;
      if (dph > 8'h01) bad = 1'b1;
      if (fsk_tone_o !== fsk_phase_o[7]) bad = 1'b1;
      adv += dph;
    end
    prev = fsk_phase_o;
    if (psk_on) begin
      if (synced && ph == 0) begin
        db = {db[2:0], sync_bit_o};
        parse(sync_bit_o);
        if (sym_stb_o) sym_chk();
      end
      if (sym_stb_o) begin
        if (synced) `CHK(cyc - t_stb, nb * per)
        else q_prev = sym_o.quad;
        synced = 1'b1;
        t_stb = cyc;
        ph = 0;
      end
      ph = (ph + 1) % per;
    end
  end

  // Whole run needs about 75k cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 100000) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, cyc, 0);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic regs();
    logic [31:0] r;
    logic [7:0]  v;
    `CHK(route_o, 8'h50)
    reg_rd(4'hf, v);
    `CHK(v, 8'h00)
    for (int i = 0; i < 8; i++) begin
      r = xs();
      reg_wr(ADDR_CTRL, r[7:0]);
      `CHK(route_o.tx_hi, r[2])
      `CHK(route_o.rx_hi, ~r[2])
      `CHK(route_o.notch_1800, r[3])
      `CHK(route_o.fsk_en, !(r[1:0] == 2'h1 || r[1:0] == 2'h2))
      reg_wr(ADDR_LEVEL, r[15:8]);
      `CHK(route_o.atten, r[11:8])
      reg_rd(ADDR_CTRL, v);
      `CHK(v, r[7:0] & 8'h3f)
      reg_rd(ADDR_LEVEL, v);
      `CHK(v, r[15:8] & 8'h0f)
    end
  endtask

  task automatic fsk_run(input logic [1:0] s, input logic a);
    longint inc;
    reg_wr(ADDR_CTRL, {2'b00, s, 1'b0, a, 2'b00});
    repeat (8) @(posedge mclk_i);
    bad = 1'b0;
    mon = 1'b1;
    for (int m = 0; m < 2; m++) begin
      src.level(m[0]);
      repeat (8) @(posedge mclk_i);
      adv = 0;
      repeat (4096) @(posedge mclk_i);
      inc = (longint'(HZ[s*4 + a*2 + m]) * 64'd16777216 + 25000000) / 50000000;
      `CHK(adv == inc / 16 || adv == inc / 16 + 1, 1'b1)
    end
    mon = 1'b0;
    `CHK(bad, 1'b0)
  endtask

  task automatic psk_run(input logic [1:0] spd, input real bit_ns, input int n,
                         input bit fast);
    logic [31:0] r;
    logic [7:0]  d0, d1, v, i0, i1;
    per = (spd == 2'h2) ? PH : PL;
    nb = (spd == 2'h2) ? 4 : 2;
    r = xs();
    reg_wr(ADDR_CTRL, {4'h0, r[1:0], spd});
    // Tone runs leave a stray character in the hold stage; let it drain
    repeat (12 * per) @(posedge mclk_i);
    reg_wr(ADDR_STAT, 8'h20);
    reg_rd(ADDR_DEL, d0);
    reg_rd(ADDR_INS, i0);
    {synced, warm, st, ins, dels, got, ph} = '0;
    psk_on = 1'b1;
    repeat (8 * per) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      r = xs();
      expq.push_back(r[7:0]);
      src.send_char(r[7:0], bit_ns);
    end
    repeat (30 * per) @(posedge mclk_i);
    psk_on = 1'b0;
    `CHK(expq.size(), 0)
    reg_rd(ADDR_DEL, d1);
    `CHK(d1 - d0, dels[7:0])
    reg_rd(ADDR_STAT, v);
    `CHK(v[5], 1'b0)
    `CHK(v[4], 1'b0)
    `CHK(fsk_phase_o, 8'h00)
    reg_rd(ADDR_INS, i1);
    `CHK(i1 != i0, 1'b1)
    if (fast) `CHK(dels != 0, 1'b1)
    else `CHK(ins != 0 && dels == 0, 1'b1)
  endtask

  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    regs();
    $display("test registers done");
    for (int s = 0; s < 3; s++) begin
      for (int a = 0; a < 2; a++) begin
        fsk_run(s[1:0], a[0]);
      end
    end
    $display("test tones done");
    psk_run(2'h2, 800.0 / 1.023, 24, 1'b1);
    $display("test fast 2400 done");
    psk_run(2'h1, 1600.0 * 1.025, 12, 1'b0);
    $display("test slow 1200 done");
    end_sim();
  end
endmodule
